// file: hdl/pmd_top.sv
`timescale 1ns/1ps
module pmd_top
  import pmd_pkg::*;
#(
  parameter int DEC_W = PMD_ADDR_W
)
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output pmd_off_t         periph_off_q
);
  // ==========================================================
  // Parameter check
  if (DEC_W < 2 || DEC_W > 31)
  begin : g_dec_w_check
    $error("pmd_top: DEC_W out of range");
  end

  // ==========================================================
  // Address decode, shared by both channels
  function automatic logic pmd_addr_hit(input logic [31:0] addr);
    return addr[DEC_W-1:0] == PMD_CTRL1_ADDR[DEC_W-1:0] && addr[31:DEC_W] == '0;
  endfunction

  // ==========================================================
  // Write channel: capture address and data in either order
  logic        aw_held_q;
  logic        w_held_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [15:0] ctrl_q;

  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire wr_go    = aw_held_q && w_held_q && !s_axi_bvalid;
  wire wr_hit   = pmd_addr_hit(awaddr_q);
  wire rd_hit   = pmd_addr_hit(s_axi_araddr);
  wire ar_take  = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= PMD_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held_q && !aw_take && !wr_go;
      s_axi_wready  <= !w_held_q && !w_take && !wr_go;
      if (aw_take)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? PMD_RESP_OKAY : PMD_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Control register
  pmd_ctrl_reg u_ctrl (
    .mclk    (mclk),
    .srst    (srst),
    .wr_en   (wr_go && wr_hit),
    .wr_data (wdata_q),
    .wr_strb (wstrb_q),
    .value_q (ctrl_q)
  );

  // ==========================================================
  // Read channel
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= PMD_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_hit ? {16'h0000, ctrl_q} : 32'h0000_0000;
        s_axi_rresp  <= rd_hit ? PMD_RESP_OKAY : PMD_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Disable outputs, registered
  pmd_off_t off_d;
  assign off_d.timer_five_off      = ctrl_q[PMD_B_TMR5];
  assign off_d.timer_four_off      = ctrl_q[PMD_B_TMR4];
  assign off_d.timer_three_off     = ctrl_q[PMD_B_TMR3];
  assign off_d.timer_two_off       = ctrl_q[PMD_B_TMR2];
  assign off_d.timer_one_off       = ctrl_q[PMD_B_TMR1];
  assign off_d.encoder_if_off      = ctrl_q[PMD_B_ENC];
  assign off_d.pwm_unit_off        = ctrl_q[PMD_B_PWM];
  assign off_d.two_wire_one_off    = ctrl_q[PMD_B_TWI1];
  assign off_d.serial_port_two_off = ctrl_q[PMD_B_SER2];
  assign off_d.serial_port_one_off = ctrl_q[PMD_B_SER1];
  assign off_d.sync_serial_two_off = ctrl_q[PMD_B_SSP2];
  assign off_d.sync_serial_one_off = ctrl_q[PMD_B_SSP1];
  assign off_d.can_ctrl_off        = ctrl_q[PMD_B_CAN];
  assign off_d.adc_off             = ctrl_q[PMD_B_ADC];

  always_ff @(posedge mclk)
  begin
    if (srst)
      periph_off_q <= '0;
    else
      periph_off_q <= off_d;
  end
endmodule

// file: hdl/pmd_pkg.sv
package pmd_pkg;
  // ==========================================================
  // Register map
  localparam logic [31:0] PMD_CTRL1_ADDR  = 32'h0000_0000;
  localparam int          PMD_ADDR_W      = 4;
  localparam logic [15:0] PMD_CTRL1_RESET = 16'h0000;
  localparam logic [15:0] PMD_CTRL1_MASK  = 16'hFEFB;
  // ==========================================================
  // Field positions
  localparam int PMD_B_TMR5  = 15;
  localparam int PMD_B_TMR4  = 14;
  localparam int PMD_B_TMR3  = 13;
  localparam int PMD_B_TMR2  = 12;
  localparam int PMD_B_TMR1  = 11;
  localparam int PMD_B_ENC   = 10;
  localparam int PMD_B_PWM   = 9;
  localparam int PMD_B_TWI1  = 7;
  localparam int PMD_B_SER2  = 6;
  localparam int PMD_B_SER1  = 5;
  localparam int PMD_B_SSP2  = 4;
  localparam int PMD_B_SSP1  = 3;
  localparam int PMD_B_CAN   = 1;
  localparam int PMD_B_ADC   = 0;
  // ==========================================================
  // AXI responses
  localparam logic [1:0] PMD_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PMD_RESP_SLVERR = 2'h2;
  // ==========================================================
  // Peripheral disable outputs
  typedef struct packed {
    logic       timer_five_off;
    logic       timer_four_off;
    logic       timer_three_off;
    logic       timer_two_off;
    logic       timer_one_off;
    logic       encoder_if_off;
    logic       pwm_unit_off;
    logic       two_wire_one_off;
    logic       serial_port_two_off;
    logic       serial_port_one_off;
    logic       sync_serial_two_off;
    logic       sync_serial_one_off;
    logic       can_ctrl_off;
    logic       adc_off;
  } pmd_off_t;
endpackage

// file: hdl/pmd_ctrl_reg.sv
`timescale 1ns/1ps
module pmd_ctrl_reg
  import pmd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  input  wire logic [3:0]  wr_strb,
  output logic      [15:0] value_q
);
  // ==========================================================
  // Byte-lane merge, unimplemented bits kept zero
  logic [15:0] merged;
  logic [15:0] value_d;
  assign merged[7:0]  = wr_strb[0] ? wr_data[7:0]  : value_q[7:0];
  assign merged[15:8] = wr_strb[1] ? wr_data[15:8] : value_q[15:8];
  assign value_d = wr_en ? (merged & PMD_CTRL1_MASK) : value_q;

  always_ff @(posedge mclk)
  begin
    if (srst)
      value_q <= PMD_CTRL1_RESET;
    else
      value_q <= value_d;
  end
endmodule

// file: test/pmd_top_monitor.sv
`timescale 1ns/1ps
module pmd_top_monitor
  import pmd_pkg::*;
(
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire pmd_off_t    periph_off_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // ==========================================================
  // Read data mirrors the disable outputs
  wire ok = s_axi_rvalid && s_axi_rresp == PMD_RESP_OKAY && !s_axi_bvalid;
  wire [31:0] d = s_axi_rdata;
  wire [13:0] o = periph_off_q;
  property p_tmr; ok |-> d[15:11] == o[13:9]; endproperty
  a_tmr: assert property (p_tmr) else $error("timer bits");
  property p_enc; ok |-> d[10] == periph_off_q.encoder_if_off; endproperty
  a_enc: assert property (p_enc) else $error("encoder bit");
  property p_pwm; ok |-> d[9] == periph_off_q.pwm_unit_off; endproperty
  a_pwm: assert property (p_pwm) else $error("pwm bit");
  property p_mid; ok |-> d[7:4] == o[6:3]; endproperty
  a_mid: assert property (p_mid) else $error("serial bits");
  property p_low; ok |-> d[3] == o[2] && d[1:0] == o[1:0]; endproperty
  a_low: assert property (p_low) else $error("low bits");
  property p_rsv; s_axi_rvalid |-> d[31:16] == 0 && !d[8] && !d[2]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_rst; $past(srst) |-> o == 0 && !s_axi_bvalid && !s_axi_rvalid; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_chg; !$past(srst) && o != $past(o) |-> $past(s_axi_bvalid); endproperty
  a_chg: assert property (p_chg) else $error("output change");
  property p_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write answer");
  c_all: cover property (ok && d[15:0] == 16'hFEFB);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == PMD_RESP_SLVERR);
  c_wr: cover property ($rose(s_axi_bvalid));
endmodule
bind pmd_top pmd_top_monitor u_mon (.*);

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pmd_pkg::*;
  logic mclk, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  pmd_off_t periph_off_q;
  int error_cnt = 0;
  int n_tests = 0;
  `define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
  pmd_top DUT (.*);
  initial
  begin
    {mclk, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h20;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    forever #2.5 mclk = ~mclk;
  end
  // ==========================================================
  // Bus cycles
  task automatic wr(input logic [31:0] a, input logic [15:0] v, input logic [3:0] s);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, v};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin do @(posedge mclk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
      begin do @(posedge mclk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
    join
    while (!s_axi_bvalid) @(posedge mclk);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [31:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge mclk);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk(input logic [15:0] v);
    rdr(PMD_CTRL1_ADDR);
    `CHK("rdata", {16'h0000, v}, rd)
    `CHK("rresp", PMD_RESP_OKAY, rsp)
    `CHK("off", pmd_off_t'({v[15:9], v[7:3], v[1:0]}), periph_off_q)
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_walk;
    chk(16'h0000);
    for (int i = 0; i < 16; i++)
    begin
      wr(PMD_CTRL1_ADDR, 16'h0001 << i, 4'h3);
      `CHK("bresp", PMD_RESP_OKAY, rsp)
      chk((16'h0001 << i) & 16'hFEFB);
    end
    $display("t_walk done");
  endtask
  task automatic t_rsv;
    wr(PMD_CTRL1_ADDR, 16'hFFFF, 4'h3);
    chk(16'hFEFB);
    wr(PMD_CTRL1_ADDR, 16'h0000, 4'h1);
    chk(16'hFE00);
    $display("t_rsv done");
  endtask
  task automatic t_bad;
    wr(32'h0000_0004, 16'h0000, 4'h3);
    `CHK("bresp", PMD_RESP_SLVERR, rsp)
    chk(16'hFE00);
    rdr(32'h0000_0004);
    `CHK("bad rdata", 32'h0000_0000, rd)
    `CHK("bad rresp", PMD_RESP_SLVERR, rsp)
    $display("t_bad done");
  endtask
  task automatic t_mid;
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(16'h0000);
    $display("t_mid done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_walk();
    t_rsv();
    t_bad();
    t_mid();
    wrap_up();
  end
  initial
  begin
    #20000;
    error_cnt++;
    wrap_up();
  end
endmodule
